/* File: src/buck_regs_defines.vh */
// Register offsets, field positions, reset values and read masks of the control block.
// Assumes inclusion by bare name from the design files.
`ifndef BUCK_REGS_DEFINES_VH
`define BUCK_REGS_DEFINES_VH
`define ADDR_DISCHARGE_CTRL   8'h12
`define ADDR_SWITCH_MODE      8'h14
`define ADDR_PEAK_LIMIT       8'h16
`define ADDR_EVENT_STATUS     8'h18
`define BIT_DISCHARGE         4
`define BIT_FORCED_LOW        7
`define BIT_FORCED_HIGH       6
`define BIT_PEAK_MSB          7
`define BIT_PEAK_LSB          6
`define BIT_OVERCURRENT       7
`define BIT_SHORT_CIRCUIT     4
`define BIT_UNDERVOLTAGE      1
`define RST_DISCHARGE         1'h1
`define RST_FORCED_LOW        1'h1
`define RST_FORCED_HIGH       1'h1
`define RST_PEAK_LIMIT        2'h3
`define RST_EVENT             1'h0
`define MASK_DISCHARGE        8'h10
`define MASK_SWITCH_MODE      8'hC0
`define MASK_PEAK_LIMIT       8'hC0
`define MASK_EVENT_STATUS     8'h92
`endif

/* File: src/pin_sync.v */
// Two-flop synchroniser for a single asynchronous level.
// Assumes the input comes from a pin outside the mclk domain.
`timescale 1ns/1ps
module pin_sync (
    // Clock and reset
    input  wire mclk,
    input  wire srst,
    // Level in and out
    input  wire async_in,
    output reg  sync_out
);
    reg meta_reg;

    always @(posedge mclk) begin
        if (srst) begin
            meta_reg <= 1'b0;
            sync_out <= 1'b0;
        end else begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end
endmodule

/* File: src/event_flag.v */
// One sticky protection event flag that software clears by writing zero.
// Assumes the event input is already in the mclk domain.
`timescale 1ns/1ps
`include "buck_regs_defines.vh"
module event_flag (
    // Clock and reset
    input  wire mclk,
    input  wire srst,
    // Event and clear
    input  wire event_in,
    input  wire clear_in,
    output reg  flag_reg
);
    always @(posedge mclk) begin
        if (srst) begin
            flag_reg <= `RST_EVENT;
        end else if (event_in) begin
            flag_reg <= 1'b1;
        end else if (clear_in) begin
            flag_reg <= 1'b0;
        end
    end
endmodule

/* File: src/buck_control_status_regs.v */
// Control and status registers of a step-down converter, reached over a simple byte port.
// Assumes the serial interface front end delivers byte writes and reads in the mclk domain,
// and that analog pins and protection detectors are asynchronous to mclk.
`timescale 1ns/1ps
`include "buck_regs_defines.vh"
module buck_control_status_regs (
    // Clock and reset
    input  wire       mclk,
    input  wire       srst,
    // Register port from the serial interface
    input  wire [7:0] reg_addr,
    input  wire [7:0] reg_wdata,
    input  wire       reg_wr,
    input  wire       reg_rd,
    output reg  [7:0] reg_rdata,
    output reg        reg_rvalid,
    // Pins and profile gates
    input  wire       enable_pin,
    input  wire       profile_selector_pin,
    input  wire       low_profile_enable_gate,
    input  wire       high_profile_enable_gate,
    // Protection detectors
    input  wire       overcurrent_detect,
    input  wire       short_circuit_detect,
    input  wire       undervoltage_detect,
    // Converter control
    output reg        converter_enable,
    output reg        discharge_active,
    output reg        forced_continuous,
    output reg  [1:0] peak_limit_code
);
    reg        discharge_reg;
    reg        forced_switching_low_profile;
    reg        forced_switching_high_profile;
    reg  [1:0] peak_limit_reg;
    wire       enable_s;
    wire       selector_s;
    wire       ocp_s;
    wire       scp_s;
    wire       uv_s;
    wire       overcurrent_event_flag;
    wire       short_circuit_event_flag;
    wire       input_undervoltage_event_flag;
    wire       status_wr;
    wire       enable_now;
    reg  [7:0] read_mux;
    reg        discharge_next;
    reg        forced_switching_low_profile_next;
    reg        forced_switching_high_profile_next;
    reg  [1:0] peak_limit_next;
    wire       wr_discharge;
    wire       wr_mode;
    wire       wr_peak;
    wire       forced_now;
    wire       discharge_now;
    wire       ocp_clear;
    wire       scp_clear;
    wire       uv_clear;
    wire       uv_event;
    wire [7:0] discharge_image;
    wire [7:0] mode_image;
    wire [7:0] peak_image;
    wire [7:0] status_image;

    function hit;
        input [7:0] addr;
        input [7:0] target;
        begin
            hit = (addr == target);
        end
    endfunction

    function [7:0] place_bit;
        input         value;
        input integer pos;
        begin
            place_bit      = 8'h00;
            place_bit[pos] = value;
        end
    endfunction

    // Pin synchronisers.
    pin_sync u_sync_en (
        .mclk     (mclk),
        .srst     (srst),
        .async_in (enable_pin),
        .sync_out (enable_s)
    );

    pin_sync u_sync_sel (
        .mclk     (mclk),
        .srst     (srst),
        .async_in (profile_selector_pin),
        .sync_out (selector_s)
    );

    pin_sync u_sync_ocp (
        .mclk     (mclk),
        .srst     (srst),
        .async_in (overcurrent_detect),
        .sync_out (ocp_s)
    );

    pin_sync u_sync_scp (
        .mclk     (mclk),
        .srst     (srst),
        .async_in (short_circuit_detect),
        .sync_out (scp_s)
    );

    pin_sync u_sync_uv (
        .mclk     (mclk),
        .srst     (srst),
        .async_in (undervoltage_detect),
        .sync_out (uv_s)
    );

    // Write decode and derived controls.
    assign wr_discharge  = reg_wr & hit(reg_addr, `ADDR_DISCHARGE_CTRL);
    assign wr_mode       = reg_wr & hit(reg_addr, `ADDR_SWITCH_MODE);
    assign wr_peak       = reg_wr & hit(reg_addr, `ADDR_PEAK_LIMIT);
    assign status_wr     = reg_wr & hit(reg_addr, `ADDR_EVENT_STATUS);

    assign enable_now    = enable_s & (selector_s ? high_profile_enable_gate
                                                  : low_profile_enable_gate);
    assign forced_now    = selector_s ? forced_switching_high_profile
                                      : forced_switching_low_profile;
    assign discharge_now = ~enable_now & discharge_reg;

    assign ocp_clear     = status_wr & ~reg_wdata[`BIT_OVERCURRENT];
    assign scp_clear     = status_wr & ~reg_wdata[`BIT_SHORT_CIRCUIT];
    assign uv_clear      = status_wr & ~reg_wdata[`BIT_UNDERVOLTAGE];
    assign uv_event      = uv_s & converter_enable;

    // Protection event flags.
    event_flag u_ocp (
        .mclk     (mclk),
        .srst     (srst),
        .event_in (ocp_s),
        .clear_in (ocp_clear),
        .flag_reg (overcurrent_event_flag)
    );

    event_flag u_scp (
        .mclk     (mclk),
        .srst     (srst),
        .event_in (scp_s),
        .clear_in (scp_clear),
        .flag_reg (short_circuit_event_flag)
    );

    event_flag u_uv (
        .mclk     (mclk),
        .srst     (srst),
        .event_in (uv_event),
        .clear_in (uv_clear),
        .flag_reg (input_undervoltage_event_flag)
    );

    // Next values of the writable control fields.
    always @* begin
        discharge_next = discharge_reg;
        if (wr_discharge) begin
            discharge_next = reg_wdata[`BIT_DISCHARGE];
        end
    end

    always @* begin
        forced_switching_low_profile_next = forced_switching_low_profile;
        if (wr_mode) begin
            forced_switching_low_profile_next = reg_wdata[`BIT_FORCED_LOW];
        end
    end

    always @* begin
        forced_switching_high_profile_next = forced_switching_high_profile;
        if (wr_mode) begin
            forced_switching_high_profile_next = reg_wdata[`BIT_FORCED_HIGH];
        end
    end

    always @* begin
        peak_limit_next = peak_limit_reg;
        if (wr_peak) begin
            peak_limit_next = reg_wdata[`BIT_PEAK_MSB:`BIT_PEAK_LSB];
        end
    end

    // Writable control fields.
    always @(posedge mclk) begin
        if (srst) begin
            discharge_reg <= `RST_DISCHARGE;
        end else begin
            discharge_reg <= discharge_next;
        end
    end

    always @(posedge mclk) begin
        if (srst) begin
            forced_switching_low_profile <= `RST_FORCED_LOW;
        end else begin
            forced_switching_low_profile <= forced_switching_low_profile_next;
        end
    end

    always @(posedge mclk) begin
        if (srst) begin
            forced_switching_high_profile <= `RST_FORCED_HIGH;
        end else begin
            forced_switching_high_profile <= forced_switching_high_profile_next;
        end
    end

    always @(posedge mclk) begin
        if (srst) begin
            peak_limit_reg <= `RST_PEAK_LIMIT;
        end else begin
            peak_limit_reg <= peak_limit_next;
        end
    end

    // Byte images of the mapped registers.
    assign discharge_image = place_bit(discharge_reg, `BIT_DISCHARGE);
    assign mode_image      = place_bit(forced_switching_low_profile, `BIT_FORCED_LOW)
                           | place_bit(forced_switching_high_profile, `BIT_FORCED_HIGH);
    assign peak_image      = place_bit(peak_limit_reg[1], `BIT_PEAK_MSB)
                           | place_bit(peak_limit_reg[0], `BIT_PEAK_LSB);
    assign status_image    = place_bit(overcurrent_event_flag, `BIT_OVERCURRENT)
                           | place_bit(short_circuit_event_flag, `BIT_SHORT_CIRCUIT)
                           | place_bit(input_undervoltage_event_flag, `BIT_UNDERVOLTAGE);

    // Read data with reserved bits forced to zero.
    always @* begin
        read_mux = 8'h00;
        case (reg_addr)
            `ADDR_DISCHARGE_CTRL: begin
                read_mux = discharge_image;
            end
            `ADDR_SWITCH_MODE: begin
                read_mux = mode_image;
            end
            `ADDR_PEAK_LIMIT: begin
                read_mux = peak_image;
            end
            `ADDR_EVENT_STATUS: begin
                read_mux = status_image;
            end
            default: begin
                read_mux = 8'h00;
            end
        endcase
    end

    // Registered read answer.
    always @(posedge mclk) begin
        if (srst) begin
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= reg_rd;
        end
    end

    always @(posedge mclk) begin
        if (srst) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            reg_rdata <= read_mux;
        end
    end

    // Converter control outputs.
    always @(posedge mclk) begin
        if (srst) begin
            converter_enable <= 1'b0;
        end else begin
            converter_enable <= enable_now;
        end
    end

    always @(posedge mclk) begin
        if (srst) begin
            discharge_active <= 1'b0;
        end else begin
            discharge_active <= discharge_now;
        end
    end

    always @(posedge mclk) begin
        if (srst) begin
            forced_continuous <= 1'b1;
        end else begin
            forced_continuous <= forced_now;
        end
    end

    always @(posedge mclk) begin
        if (srst) begin
            peak_limit_code <= `RST_PEAK_LIMIT;
        end else begin
            peak_limit_code <= peak_limit_reg;
        end
    end
endmodule

/* File: verif/buck_regs_monitor.sv */
// Checker of the register port and of the converter control outputs other than converter_enable.
// Assumes binding to buck_control_status_regs, one clock mclk and sync reset srst.
`timescale 1ns/1ps
`include "buck_regs_defines.vh"
module buck_regs_monitor (
    // Clock and reset
    input wire       mclk,
    input wire       srst,
    // Register port
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire       reg_wr,
    input wire       reg_rd,
    input wire [7:0] reg_rdata,
    input wire       reg_rvalid,
    // Pins and converter control
    input wire       profile_selector_pin,
    input wire       discharge_active,
    input wire       forced_continuous,
    input wire [1:0] peak_limit_code
);
    default clocking @(posedge mclk); endclocking
    default disable iff (srst);
    sequence s_wr(a); reg_wr && reg_addr == a; endsequence
    sequence s_rd_one; reg_rd ##1 !reg_rd; endsequence
    sequence s_ans(a); reg_rvalid && $past(reg_addr) == a; endsequence
    sequence s_discharge_clear; reg_wr && reg_addr == 8'h12 && !reg_wdata[4]; endsequence
    chk_rvalid_pulse: assert property (s_rd_one |-> reg_rvalid ##1 !reg_rvalid)
        else $error("read answer not a single pulse");
    chk_unmapped_zero: assert property (reg_rvalid && !($past(reg_addr) inside
        {8'h12, 8'h14, 8'h16, 8'h18}) |-> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    chk_status_reserved: assert property (s_ans(`ADDR_EVENT_STATUS) |->
        (reg_rdata & ~`MASK_EVENT_STATUS) == 8'h00) else $error("status reserved bits set");
    chk_mode_reserved: assert property (s_ans(`ADDR_SWITCH_MODE) |->
        reg_rdata[5:0] == 6'h00) else $error("mode reserved bits set");
    chk_peak_write: assert property (s_wr(8'h16) |=> ##1
        peak_limit_code == $past(reg_wdata[7:6], 2)) else $error("peak code not applied");
    chk_discharge_off: assert property (s_discharge_clear |=> ##1
        !discharge_active) else $error("discharge stays on");
    chk_forced_low: assert property (!profile_selector_pin [*4] ##0 s_wr(8'h14) |=> ##1
        forced_continuous == $past(reg_wdata[7], 2)) else $error("low profile mode wrong");
    chk_rdata_hold: assert property (!reg_rvalid && !$past(srst) |-> $stable(reg_rdata))
        else $error("read data moved without answer");
endmodule
bind buck_control_status_regs buck_regs_monitor mon (
    .mclk                 (mclk),
    .srst                 (srst),
    .reg_addr             (reg_addr),
    .reg_wdata            (reg_wdata),
    .reg_wr               (reg_wr),
    .reg_rd               (reg_rd),
    .reg_rdata            (reg_rdata),
    .reg_rvalid           (reg_rvalid),
    .profile_selector_pin (profile_selector_pin),
    .discharge_active     (discharge_active),
    .forced_continuous    (forced_continuous),
    .peak_limit_code      (peak_limit_code)
);

/* File: verif/host_model.sv */
// Host side of the register port issuing single byte writes and reads.
// Assumes the block takes strobes at the rising edge of mclk.
`timescale 1ns/1ps
module host_model (
    // Clock and read answer
    input  wire       mclk,
    input  wire [7:0] reg_rdata,
    input  wire       reg_rvalid,
    // Request
    output reg  [7:0] reg_addr  = 8'h00,
    output reg  [7:0] reg_wdata = 8'h00,
    output reg        reg_wr    = 1'b0,
    output reg        reg_rd    = 1'b0
);
    task wr(input [7:0] a, input [7:0] dv); begin
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= dv;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
        reg_addr <= ~a;
        reg_wdata <= ~dv;
    end endtask
    task rd(input [7:0] a, output [7:0] dv, output vv); begin
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        reg_addr <= ~a;
        @(posedge mclk);
        vv = reg_rvalid;
        dv = reg_rdata;
    end endtask
endmodule

/* File: verif/test_buck_control_status_regs.sv */
// Self-checking bench of the control and status registers.
// Assumes host_model drives the register port and the bench drives pins.
`timescale 1ns/1ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin failures++; \
    $display("CHECK FAILED %0t got %h exp %h", $time, g, e); end end
module test_buck_control_status_regs;
    reg mclk = 0, srst = 1, en = 0, sel = 0, gl = 0, gh = 0, v;
    reg [2:0] det = 3'h0;
    reg [7:0] d;
    wire [7:0] ra, wd, rdat;
    wire wr, rd, rv, ce, dis, fc;
    wire [1:0] pk;
    integer failures = 0, checks_done = 0, i;
    reg [23:0] rows [0:7] = '{24'h12FF10, 24'h120000, 24'h14FFC0, 24'h143F00,
        24'h167F40, 24'h168080, 24'h13FF00, 24'h18FF00};
    always #2 mclk = ~mclk;
    host_model host (.mclk(mclk), .reg_rdata(rdat), .reg_rvalid(rv), .reg_addr(ra),
        .reg_wdata(wd), .reg_wr(wr), .reg_rd(rd));
    buck_control_status_regs dut (.mclk(mclk), .srst(srst), .reg_addr(ra), .reg_wdata(wd),
        .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdat), .reg_rvalid(rv), .enable_pin(en),
        .profile_selector_pin(sel), .low_profile_enable_gate(gl),
        .high_profile_enable_gate(gh), .overcurrent_detect(det[2]),
        .short_circuit_detect(det[1]), .undervoltage_detect(det[0]), .converter_enable(ce),
        .discharge_active(dis), .forced_continuous(fc), .peak_limit_code(pk));
    task rchk(input [7:0] a, input [7:0] e); begin
        host.rd(a, d, v);
        `CHK(v, 1'b1)
        `CHK(d, e)
    end endtask
    task settle; repeat (6) @(posedge mclk); endtask
    task tally_and_finish; begin
        if (failures == 0 && checks_done > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    end endtask
    initial begin
        repeat (8) @(posedge mclk);
        srst <= 1'b0;
        for (i = 0; i < 8; i++) begin
            host.wr(rows[i][23:16], rows[i][15:8]);
            rchk(rows[i][23:16], rows[i][7:0]);
        end
        `CHK(pk, 2'h2)
        @(posedge mclk) srst <= 1'b1;
        @(posedge mclk) srst <= 1'b0;
        rchk(8'h12, 8'h10);
        rchk(8'h14, 8'hC0);
        rchk(8'h16, 8'hC0);
        rchk(8'h18, 8'h00);
        `CHK({fc, pk, dis}, 4'hF)
        det <= 3'h7;
        settle;
        det <= 3'h0;
        rchk(8'h18, 8'h90);
        host.wr(8'h18, 8'h10);
        rchk(8'h18, 8'h10);
        host.wr(8'h18, 8'h00);
        rchk(8'h18, 8'h00);
        en <= 1'b1;
        gl <= 1'b1;
        det <= 3'h1;
        settle;
        `CHK({ce, dis}, 2'h2)
        host.wr(8'h18, 8'h00);
        rchk(8'h18, 8'h02);
        det <= 3'h0;
        host.wr(8'h14, 8'h40);
        settle;
        `CHK(fc, 1'b0)
        sel <= 1'b1;
        settle;
        `CHK({fc, ce, dis}, 3'h5)
        gh <= 1'b1;
        settle;
        `CHK({ce, dis}, 2'h2)
        host.wr(8'h12, 8'h00);
        en <= 1'b0;
        settle;
        `CHK({ce, dis}, 2'h0)
        tally_and_finish;
    end
endmodule
